// ---- acm_pkg.sv ----
// acm_pkg: shared constants for the conversion mode controller.
// assumes a 200 MHz core clock and 8-bit register accesses.
package acm_pkg;

   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] ACM_MAIN_CONFIG_OFS   = 8'h20;
   localparam logic [7:0] ACM_AUX_CONFIG_OFS    = 8'h22;
   localparam logic [7:0] ACM_STATUS_OFS        = 8'h27;
   localparam logic [7:0] ACM_MOTION_THR_OFS    = 8'h34;
   localparam logic [7:0] ACM_MOTION_TIMING_OFS = 8'h35;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [7:0] ACM_MAIN_CONFIG_RST   = 8'h00;
   localparam logic [7:0] ACM_AUX_CONFIG_RST    = 8'h00;
   localparam logic [7:0] ACM_MOTION_THR_RST    = 8'h00;
   localparam logic [7:0] ACM_MOTION_TIMING_RST = 8'h00;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int ACM_POWER_LEVEL_LSB   = 0;   // main [1:0]
   localparam int ACM_CONV_KIND_LSB     = 2;   // main [3:2]
   localparam int ACM_SOFT_TRIGGER_BIT  = 0;   // aux
   localparam int ACM_TRIGGER_SRC_BIT   = 1;   // aux
   localparam int ACM_EVENT_ROUTE_BIT   = 2;   // aux
   localparam int ACM_ACTUATION_LSB     = 6;   // aux [7:6]
   localparam int ACM_THRESHOLD_LSB     = 0;   // threshold [5:0]
   localparam int ACM_IDLE_RATE_EN_BIT  = 6;   // threshold
   localparam int ACM_SLEEP_DUR_LSB     = 0;   // timing [3:0]
   localparam int ACM_MOTIONLESS_EN_BIT = 4;   // timing
   localparam int ACM_STAT_READY_BIT    = 0;
   localparam int ACM_STAT_SLEEP_BIT    = 1;

   // -------------------------------------------------------------
   // encodings
   // -------------------------------------------------------------
   localparam logic [1:0] ACM_KIND_ONDEMAND = 2'h2;
   localparam logic [1:0] ACM_ACT_OFF       = 2'h0;
   localparam logic [1:0] ACM_ACT_NEGATIVE  = 2'h2;
   localparam int         ACM_THR_SHIFT     = 6;   // threshold lsb weight

   typedef enum logic [2:0] {
      ACM_OFF    = 3'h1,
      ACM_TURNON = 3'h2,
      ACM_STORE  = 3'h4
   } acm_conv_state_t;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int ACM_CLK_PERIOD_PS = 5000;
   localparam int ACM_TON_PL1_NS    = 1200000;   // 1.20 ms
   localparam int ACM_TON_PL2_NS    = 1700000;   // 1.70 ms
   localparam int ACM_TON_PL3_NS    = 2300000;   // 2.30 ms
   localparam int ACM_TON_PL4_NS    = 3550000;   // 3.55 ms
   localparam int ACM_FAST_RATE_MHZ = 100000000; // 100 Hz in micro-hertz
   localparam int ACM_IDLE_RATE_MHZ = 12500000;  // 12.5 Hz in micro-hertz
   localparam int ACM_TON_PL1_CYC = ACM_TON_PL1_NS / (ACM_CLK_PERIOD_PS / 1000);
   localparam int ACM_TON_PL2_CYC = ACM_TON_PL2_NS / (ACM_CLK_PERIOD_PS / 1000);
   localparam int ACM_TON_PL3_CYC = ACM_TON_PL3_NS / (ACM_CLK_PERIOD_PS / 1000);
   localparam int ACM_TON_PL4_CYC = ACM_TON_PL4_NS / (ACM_CLK_PERIOD_PS / 1000);
   localparam int ACM_FAST_PERIOD_CYC = int'(64'd200000000000000 / ACM_FAST_RATE_MHZ);
   localparam int ACM_IDLE_PERIOD_CYC = int'(64'd200000000000000 / ACM_IDLE_RATE_MHZ);

endpackage

// ---- acm_motion.sv ----
// acm_motion: sleep/wake tracker on stored samples.
// assumes sample_stb pulses once per stored sample set.
`timescale 1ns/10ps
module acm_motion
   import acm_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // samples
   input  wire logic        sample_stb,
   input  wire logic [13:0] smp_x,
   input  wire logic [13:0] smp_y,
   input  wire logic [13:0] smp_z,
   // settings
   input  wire logic        enable,
   input  wire logic [5:0]  threshold,
   input  wire logic [3:0]  duration,
   // state
   output logic             sleep_q
);
   typedef struct packed {
      logic       sleep;
      logic [3:0] quiet;
   } acm_motion_state_t;

   acm_motion_state_t s_q, s_d;
   logic [13:0]       limit;
   logic              over;

   // magnitude of a two's complement axis value
   function automatic logic [13:0] acm_mag(input logic [13:0] v);
      acm_mag = v[13] ? 14'(~v + 14'h1) : v;
   endfunction

   // any single axis above the limit counts as motion
   assign limit = 14'({threshold, 6'h00});
   assign over  = (acm_mag(smp_x) > limit) || (acm_mag(smp_y) > limit) ||
                  (acm_mag(smp_z) > limit);

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (!enable) begin
         s_d = '0;
      end else if (sample_stb) begin
         if (over) begin
            s_d.sleep = 1'b0;
            s_d.quiet = 4'h0;
         end else if (s_q.quiet >= duration) begin
            s_d.sleep = 1'b1;
         end else begin
            s_d.quiet = 4'(s_q.quiet + 4'h1);
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sleep_q = s_q.sleep;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_wake_on_motion: assert property (@(posedge clk) disable iff (rst)
      enable && sample_stb && over |=> !sleep_q)
      else $error("sleep held after axis above threshold");

endmodule // acm_motion

// ---- acm_top.sv ----
// acm_top: conversion mode controller of the accelerometer.
// assumes register accesses arrive already decoded from the serial port.
// How it works
// - continuous or single-shot style, each with four power levels.
// - kind field pattern 10 selects on-demand conversion, any power level.
// - trigger source 0 makes second event pin an input clock trigger.
// - trigger source 1 starts a conversion when host sets soft bit.
// - device clears soft bit itself when data land; ready again.
// - each on-demand sample follows the currently selected power level.
// - after storing an on-demand sample, power down until next trigger.
// - external trigger accepts any rate from zero up to maximum.
// - primary event pin shows sample ready flag or fifo status.
// - turn-on delay end raises ready, exposes data, then powers down.
// - turn-on delay 1.20, 1.70, 2.30, 3.55 ms per level.
// - actuation field 00 means self-test off, else force applied.
// - self-test output is real acceleration plus the test force.
// - idle enable drops to 12.5 Hz in sleep, wakes on event.
// - on wake the previous style and rate come back.
// - motionless detect finds sleep but changes no rate or style.
// - nonzero motion threshold enables detection and high-pass path.
// - in sleep, any axis over threshold moves to wake.
// - sample ready flag marks a fresh complete sample set.
`timescale 1ns/10ps
module acm_top
   import acm_pkg::*;
#(
   parameter int TON_PL1_CYC     = ACM_TON_PL1_CYC,
   parameter int TON_PL2_CYC     = ACM_TON_PL2_CYC,
   parameter int TON_PL3_CYC     = ACM_TON_PL3_CYC,
   parameter int TON_PL4_CYC     = ACM_TON_PL4_CYC,
   parameter int FAST_PERIOD_CYC = ACM_FAST_PERIOD_CYC,
   parameter int IDLE_PERIOD_CYC = ACM_IDLE_PERIOD_CYC,
   parameter logic [13:0] TEST_FORCE = 14'h0400
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register access
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   // sensing chain
   input  wire logic [13:0] raw_x,
   input  wire logic [13:0] raw_y,
   input  wire logic [13:0] raw_z,
   input  wire logic        fifo_event,
   output logic             sensor_powered,
   output logic             hp_filter_en,
   output logic [1:0]       actuation_drive,
   output logic [13:0]      sample_x,
   output logic [13:0]      sample_y,
   output logic [13:0]      sample_z,
   output logic             sample_ready,
   // event pins
   output logic             primary_event_pin,
   input  wire logic        secondary_pin_in,
   output logic             secondary_pin_out,
   output logic             secondary_pin_oe,
   // motion state
   output logic             sleep_state
);
   typedef struct packed {
      acm_conv_state_t st;
      logic [7:0]      main_cfg;
      logic [7:0]      aux_cfg;
      logic [7:0]      thr_cfg;
      logic [7:0]      tim_cfg;
      logic [31:0]     ton_cnt;
      logic [31:0]     rate_cnt;
      logic [1:0]      lvl_lock;
      logic            pin_prev;
      logic            ready;
      logic [13:0]     x;
      logic [13:0]     y;
      logic [13:0]     z;
      logic [7:0]      rdata;
      logic            evt;
      logic            sec_oe;
      logic            hp_en;
      logic [1:0]      act;
   } acm_state_t;

   acm_state_t s_q, s_d;

   // -------------------------------------------------------------
   // decoded settings
   // -------------------------------------------------------------
   logic [1:0]  power_level_select;
   logic [1:0]  conversion_kind_select;
   logic        ondemand_trigger_source;
   logic        soft_trigger_bit;
   logic        event_route_fifo;
   logic [1:0]  actuation_check_field;
   logic        idle_rate_en;
   logic        motionless_en;
   logic        motion_en;
   logic        idle_rate_active;
   logic        ondemand;
   logic        ext_edge;
   logic        rate_tick;
   logic        trigger;
   logic        wr_aux;
   logic [13:0] force_term;
   logic [13:0] nx, ny, nz;
   logic        store_stb;
   logic        sleep_q;

   // field extraction
   assign power_level_select      = s_q.main_cfg[ACM_POWER_LEVEL_LSB +: 2];
   assign conversion_kind_select  = s_q.main_cfg[ACM_CONV_KIND_LSB +: 2];
   assign ondemand_trigger_source = s_q.aux_cfg[ACM_TRIGGER_SRC_BIT];
   assign soft_trigger_bit        = s_q.aux_cfg[ACM_SOFT_TRIGGER_BIT];
   assign event_route_fifo        = s_q.aux_cfg[ACM_EVENT_ROUTE_BIT];
   assign actuation_check_field   = s_q.aux_cfg[ACM_ACTUATION_LSB +: 2];
   assign idle_rate_en            = s_q.thr_cfg[ACM_IDLE_RATE_EN_BIT];
   assign motionless_en           = s_q.tim_cfg[ACM_MOTIONLESS_EN_BIT];
   assign motion_en = (s_q.thr_cfg[ACM_THRESHOLD_LSB +: 6] != 6'h00);

   // sleeping with idle rate forces the slow continuous pace; style and
   // rate settings are never rewritten, so waking restores them as-is
   assign idle_rate_active = sleep_q && idle_rate_en;
   assign ondemand = (conversion_kind_select == ACM_KIND_ONDEMAND) &&
                     !idle_rate_active;
   assign wr_aux   = reg_wr_en && (reg_addr == ACM_AUX_CONFIG_OFS);

   // pin edge: one flop of history is enough since pins are synchronous;
   // no lower rate bound; an edge during turn-on or store is not served
   assign ext_edge = secondary_pin_in && !s_q.pin_prev;

   // turn-on length for a power level
   function automatic logic [31:0] acm_ton(input logic [1:0] lvl);
      case (lvl)
         2'h0:    acm_ton = 32'(TON_PL1_CYC);
         2'h1:    acm_ton = 32'(TON_PL2_CYC);
         2'h2:    acm_ton = 32'(TON_PL3_CYC);
         default: acm_ton = 32'(TON_PL4_CYC);
      endcase
   endfunction

   // -------------------------------------------------------------
   // trigger selection
   // -------------------------------------------------------------
   // continuous pace; idle rate is slower and wins while asleep
   assign rate_tick = idle_rate_active ?
                      (s_q.rate_cnt >= 32'(IDLE_PERIOD_CYC - 1)) :
                      (s_q.rate_cnt >= 32'(FAST_PERIOD_CYC - 1));
   always_comb begin
      if (!ondemand) begin
         trigger = rate_tick;
      end else if (ondemand_trigger_source) begin
         trigger = soft_trigger_bit;
      end else begin
         trigger = ext_edge;
      end
   end

   // self-test offset; negative code subtracts the force
   always_comb begin
      if (actuation_check_field == ACM_ACT_OFF) begin
         force_term = 14'h0000;
      end else if (actuation_check_field == ACM_ACT_NEGATIVE) begin
         force_term = 14'(~TEST_FORCE + 14'h0001);
      end else begin
         force_term = TEST_FORCE;
      end
   end

   // algebraic sum of real and simulated acceleration
   assign nx = 14'(raw_x + force_term);
   assign ny = 14'(raw_y + force_term);
   assign nz = 14'(raw_z + force_term);
   assign store_stb = (s_q.st == ACM_STORE);

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.pin_prev = secondary_pin_in;
      s_d.rate_cnt = (ondemand || rate_tick) ? 32'h0 : 32'(s_q.rate_cnt + 32'h1);

      // register writes
      if (reg_wr_en) begin
         case (reg_addr)
            ACM_MAIN_CONFIG_OFS:   s_d.main_cfg = reg_wdata;
            ACM_AUX_CONFIG_OFS:    s_d.aux_cfg  = reg_wdata;
            ACM_MOTION_THR_OFS:    s_d.thr_cfg  = reg_wdata;
            ACM_MOTION_TIMING_OFS: s_d.tim_cfg  = reg_wdata;
            default: ;
         endcase
      end

      // register reads; unmapped offsets return zero
      if (reg_rd_en) begin
         case (reg_addr)
            ACM_MAIN_CONFIG_OFS:   s_d.rdata = s_q.main_cfg;
            ACM_AUX_CONFIG_OFS:    s_d.rdata = s_q.aux_cfg;
            ACM_MOTION_THR_OFS:    s_d.rdata = s_q.thr_cfg;
            ACM_MOTION_TIMING_OFS: s_d.rdata = s_q.tim_cfg;
            ACM_STATUS_OFS: begin
               s_d.rdata = 8'h00;
               s_d.rdata[ACM_STAT_READY_BIT] = s_q.ready;
               s_d.rdata[ACM_STAT_SLEEP_BIT] = sleep_q;
               s_d.ready = 1'b0;   // read clears; a store below wins
            end
            default: s_d.rdata = 8'h00;
         endcase
      end

      // conversion sequencer
      case (s_q.st)
         ACM_OFF: begin
            if (trigger) begin
               s_d.st       = ACM_TURNON;
               s_d.lvl_lock = power_level_select;
               s_d.ton_cnt  = 32'(acm_ton(power_level_select) - 32'h1);
            end
         end
         ACM_TURNON: begin
            // triggers in this state are simply not looked at
            if (s_q.ton_cnt == 32'h0) begin
               s_d.st = ACM_STORE;
            end else begin
               s_d.ton_cnt = 32'(s_q.ton_cnt - 32'h1);
            end
         end
         ACM_STORE: begin
            s_d.x     = nx;
            s_d.y     = ny;
            s_d.z     = nz;
            s_d.ready = 1'b1;
            s_d.st    = ACM_OFF;
            // host setting the bit in this very cycle keeps it set
            if (!(wr_aux && reg_wdata[ACM_SOFT_TRIGGER_BIT])) begin
               s_d.aux_cfg[ACM_SOFT_TRIGGER_BIT] = 1'b0;
            end
         end
         default: s_d.st = ACM_OFF;
      endcase

      // pin and side outputs
      s_d.sec_oe = !(ondemand && !ondemand_trigger_source);
      s_d.evt    = event_route_fifo ? fifo_event : s_d.ready;
      s_d.hp_en  = motion_en;
      s_d.act    = actuation_check_field;
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q          <= '0;
         s_q.st       <= ACM_OFF;
         s_q.main_cfg <= ACM_MAIN_CONFIG_RST;
         s_q.aux_cfg  <= ACM_AUX_CONFIG_RST;
         s_q.thr_cfg  <= ACM_MOTION_THR_RST;
         s_q.tim_cfg  <= ACM_MOTION_TIMING_RST;
         s_q.sec_oe   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------
   // motion tracking
   // -------------------------------------------------------------
   // sleep detection runs for either function; only the idle-rate
   // variant feeds back into the pace, motionless detect just reports
   acm_motion u_motion (
      .clk        (clk),
      .rst        (rst),
      .sample_stb (store_stb),
      .smp_x      (nx),
      .smp_y      (ny),
      .smp_z      (nz),
      .enable     (motion_en && (idle_rate_en || motionless_en)),
      .threshold  (s_q.thr_cfg[ACM_THRESHOLD_LSB +: 6]),
      .duration   (s_q.tim_cfg[ACM_SLEEP_DUR_LSB +: 4]),
      .sleep_q    (sleep_q)
   );

   // outputs from flops; sensor_powered decodes the state, pin out is tied low
   assign reg_rdata         = s_q.rdata;
   assign sensor_powered    = (s_q.st != ACM_OFF);
   assign hp_filter_en      = s_q.hp_en;
   assign actuation_drive   = s_q.act;
   assign sample_x          = s_q.x;
   assign sample_y          = s_q.y;
   assign sample_z          = s_q.z;
   assign sample_ready      = s_q.ready;
   assign primary_event_pin = s_q.evt;
   assign secondary_pin_out = 1'b0;
   assign secondary_pin_oe  = s_q.sec_oe;
   assign sleep_state       = sleep_q;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [31:0] on_len_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         on_len_q <= 32'h0;
      end else begin
         on_len_q <= (s_q.st == ACM_TURNON) ? 32'(on_len_q + 32'h1) : 32'h0;
      end
   end

   sequence acm_store_seq;
      (s_q.st == ACM_TURNON) && (s_q.ton_cnt == 32'h0) ##1 (s_q.st == ACM_STORE);
   endsequence

   a_turnon_length: assert property (
      (s_q.st == ACM_TURNON) && (s_q.ton_cnt == 32'h0) |->
      (32'(on_len_q + 32'h1) == acm_ton(s_q.lvl_lock)))
      else $error("turn-on length wrong for level");
   a_ready_then_off: assert property (
      acm_store_seq |=> sample_ready && (s_q.st == ACM_OFF))
      else $error("store did not raise ready and power down");
   a_soft_self_clear: assert property (
      store_stb && !wr_aux |=> !soft_trigger_bit)
      else $error("soft trigger not cleared after store");
   a_soft_start: assert property (
      (s_q.st == ACM_OFF) && ondemand && ondemand_trigger_source &&
      soft_trigger_bit |=> (s_q.st == ACM_TURNON))
      else $error("soft trigger did not start conversion");
   a_ext_start: assert property (
      (s_q.st == ACM_OFF) && ondemand && !ondemand_trigger_source &&
      ext_edge |=> (s_q.st == ACM_TURNON) ##1 !secondary_pin_oe)
      else $error("pin edge did not start conversion");
   a_busy_ignore: assert property (
      (s_q.st == ACM_TURNON) && (s_q.ton_cnt != 32'h0) |=> (s_q.st == ACM_TURNON))
      else $error("conversion left turn-on early");
   // expected force rebuilt from the field code, not from the adder's own term
   a_selftest_sum: assert property (
      store_stb |=> sample_x == 14'($past(raw_x) +
         (($past(actuation_check_field) == ACM_ACT_OFF) ? 14'h0000 :
          ($past(actuation_check_field) == ACM_ACT_NEGATIVE) ? 14'(14'h0000 - TEST_FORCE) :
          TEST_FORCE)))
      else $error("sample is not sum of force and acceleration");
   a_event_route: assert property (
      ##1 !$past(event_route_fifo) |-> primary_event_pin == sample_ready)
      else $error("event pin does not follow ready flag");
   a_hp_follows: assert property (
      motion_en |=> hp_filter_en)
      else $error("high-pass path not enabled by threshold");

endmodule // acm_top

// ---- acm_host_model.sv ----
// acm_host_model: host side that clocks the second event pin.
// assumes the bench resolves the shared pin from the device enable alone.
`timescale 1ns/10ps
module acm_host_model (
   // clock
   input  wire logic clk,
   // trigger clock toward the device
   output logic      trig_clk
);
   // trigger clock stands low outside a request
   initial trig_clk = 1'b0;

   // one trigger period; any gap is legal, so the rate is the caller's
   task automatic tick(input int hi_cyc);
      @(negedge clk);
      trig_clk = 1'b1;
      repeat (hi_cyc) @(negedge clk);
      trig_clk = 1'b0;
   endtask
endmodule // acm_host_model

// ---- acm_top_tb_top.sv ----
// acm_top_tb_top: self-checking bench of the conversion mode controller.
// assumes short turn-on counts 20/30/40/50 and pace counts 100/800.
`timescale 1ns/10ps
module acm_top_tb_top;
   import acm_pkg::*;
   logic clk, rst, reg_wr_en, reg_rd_en, fifo_event, sec_in, sec_out, sec_oe, host_pin;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [13:0] raw_x, raw_y, raw_z, sample_x, sample_y, sample_z;
   logic powered, hp_en, ready, prim, sleep;
   logic [1:0] act;
   int err_count, total_checks;
   int ton[4] = '{20, 30, 40, 50};

   // -------------------------------------------------------------
   // clock, pin and instances
   // -------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // device drives when enabled, host otherwise
   assign sec_in = sec_oe ? sec_out : host_pin;
   acm_host_model host (.clk(clk), .trig_clk(host_pin));
   acm_top #(.TON_PL1_CYC(20), .TON_PL2_CYC(30), .TON_PL3_CYC(40), .TON_PL4_CYC(50),
      .FAST_PERIOD_CYC(100), .IDLE_PERIOD_CYC(800)) uut (
      .clk(clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z), .fifo_event(fifo_event),
      .sensor_powered(powered), .hp_filter_en(hp_en), .actuation_drive(act),
      .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
      .sample_ready(ready), .primary_event_pin(prim), .secondary_pin_in(sec_in),
      .secondary_pin_out(sec_out), .secondary_pin_oe(sec_oe), .sleep_state(sleep));

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // strobes rise at a falling edge and drop one cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd_en = 1'b0;
      d = reg_rdata;
   endtask
   // bounded wait for a level; a spent bound ends the run
   task automatic wait_for(input string what, ref logic s, input logic v, output int n);
      for (n = 0; s !== v && n < 3000; n++) @(negedge clk);
      if (s !== v) begin
         chk(what, 14'(v), 14'(s));
         conclude();
      end
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] d;
      rd(ACM_MAIN_CONFIG_OFS, d);
      chk("main reset", 14'h0000, 14'(d));
      rd(8'h10, d);
      chk("unmapped read", 14'h0000, 14'(d));
      chk("pin oe after reset", 14'h0001, 14'(sec_oe));
      chk("pin out", 14'h0000, 14'(sec_out));
      $display("test reset done");
   endtask
   // soft trigger at each level; force positive for codes 1 and 3, negative for 2
   task automatic t_soft();
      int n;
      logic [7:0] d;
      logic [13:0] f;
      for (int pl = 0; pl < 4; pl++) begin
         raw_y = 14'(14'h3FF0 - pl);
         raw_z = 14'(14'h0020 + pl);
         wr(ACM_MAIN_CONFIG_OFS, {4'h0, ACM_KIND_ONDEMAND, 2'(pl)});
         wr(ACM_AUX_CONFIG_OFS, {2'(pl), 6'h03});
         wait_for("sample_ready", ready, 1'b1, n);
         chk("turn-on window", 14'h0001, 14'(n >= ton[pl] && n <= ton[pl] + 2));
         chk("actuation", 14'(pl), 14'(act));
         f = (pl == 0) ? 14'h0000 : (pl == 2) ? 14'h3C00 : 14'h0400;
         chk("sample_x", 14'(raw_x + f), sample_x);
         chk("sample_y", 14'(raw_y + f), sample_y);
         chk("sample_z", 14'(raw_z + f), sample_z);
         chk("powered after store", 14'h0000, 14'(powered));
         rd(ACM_AUX_CONFIG_OFS, d);
         chk("soft bit", 14'h0000, 14'(d[0]));
         rd(ACM_STATUS_OFS, d);
         chk("status ready", 14'h0001, 14'(d[0]));
      end
      $display("test soft trigger done");
   endtask
   // pin trigger; a second edge during turn-on is dropped
   task automatic t_pin();
      int n;
      logic [7:0] d;
      wr(ACM_MAIN_CONFIG_OFS, 8'h09);
      wr(ACM_AUX_CONFIG_OFS, 8'h00);
      // oe is registered, so it follows the source bit one cycle late
      @(negedge clk);
      chk("pin oe", 14'h0000, 14'(sec_oe));
      host.tick(3);
      host.tick(2);
      wait_for("sample_ready", ready, 1'b1, n);
      chk("pin turn-on", 14'(ton[1] - 4), 14'(n));
      chk("primary pin", 14'h0001, 14'(prim));
      repeat (5) @(negedge clk);
      chk("no second conversion", 14'h0000, 14'(powered));
      rd(ACM_STATUS_OFS, d);
      chk("pin status ready", 14'h0001, 14'(d[0]));
      $display("test pin trigger done");
   endtask
   // threshold, fifo routing, idle-rate sleep and wake, then motionless detect
   task automatic t_motion();
      int n;
      logic [7:0] d;
      wr(ACM_MOTION_THR_OFS, 8'h41);
      wr(ACM_MOTION_TIMING_OFS, 8'h01);
      chk("high-pass enable", 14'h0001, 14'(hp_en));
      wr(ACM_AUX_CONFIG_OFS, 8'h04);
      fifo_event = 1'b1;
      repeat (2) @(negedge clk);
      chk("fifo on primary", 14'h0001, 14'(prim));
      fifo_event = 1'b0;
      wr(ACM_MAIN_CONFIG_OFS, 8'h00);
      wait_for("sleep", sleep, 1'b1, n);
      raw_x = 14'h0100;
      wait_for("wake", sleep, 1'b0, n);
      chk("idle pace", 14'h0001, 14'(n > 100 + ton[0] + 2));
      chk("wake sample", 14'h0100, sample_x);
      // fast pace is back: the next sample lands within one fast period plus turn-on
      rd(ACM_STATUS_OFS, d);
      wait_for("ready after wake", ready, 1'b1, n);
      chk("wake pace", 14'h0001, 14'(n <= 100 + ton[0] + 2));
      // motionless detect reports sleep but keeps the fast pace
      raw_x = 14'h0010;
      wr(ACM_MOTION_THR_OFS, 8'h01);
      wr(ACM_MOTION_TIMING_OFS, 8'h11);
      wait_for("motionless sleep", sleep, 1'b1, n);
      rd(ACM_STATUS_OFS, d);
      wait_for("ready in stillness", ready, 1'b1, n);
      chk("motionless pace", 14'h0001, 14'(n <= 100 + ton[0] + 2));
      $display("test motion done");
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      {reg_wr_en, reg_rd_en, fifo_event, reg_addr, reg_wdata} = '0;
      raw_x = 14'h0010;
      raw_y = 14'h3FF0;
      raw_z = 14'h0020;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      t_reset();
      t_soft();
      t_pin();
      t_motion();
      conclude();
   end
endmodule // acm_top_tb_top
